/* dmsp_defines.svh */
// Constants for the dual mode serial port: offsets, resets, rates, counts
`ifndef DMSP_DEFINES_SVH
`define DMSP_DEFINES_SVH

// Register offsets (word index on the plain register port)
`define DMSP_OFS_CTRL    4'h0
`define DMSP_OFS_TXDATA  4'h1
`define DMSP_OFS_RXDATA  4'h2
`define DMSP_OFS_STATUS  4'h3
`define DMSP_OFS_MASK    4'h4

// Reset values
`define DMSP_CTRL_RST    16'h0000
`define DMSP_MASK_RST    5'h00

// Status read-only bit positions (sticky bits sit in [4:0])
`define DMSP_ST_TXFULL   8
`define DMSP_ST_RXFULL   9
`define DMSP_ST_TXBUSY   10

// Machine clock and bit rates
`define DMSP_CLK_HZ      40000000
`define DMSP_OVERSAMPLE  16
`define DMSP_MID_TICK    4'h7
`define DMSP_LAST_TICK   4'hF
`define DMSP_ARATE0      31250
`define DMSP_ARATE1      9615
`define DMSP_ARATE2      4808
`define DMSP_ARATE3      2404
`define DMSP_ARATE4      1202
`define DMSP_SRATE0      1000000
`define DMSP_SRATE1      500000
`define DMSP_SRATE2      250000
`define DMSP_SRATE3      125000
`define DMSP_SRATE4      62500

`endif

/* dmsp_pkg.sv */
// Types shared by the dual mode serial port
package dmsp_pkg;

    typedef enum logic [1:0] {
        DMSP_ASYNC_NORMAL = 2'h0,
        DMSP_ASYNC_MP     = 2'h1,
        DMSP_SYNC         = 2'h2,
        DMSP_MODE_RSVD    = 2'h3
    } dmsp_mode_t;

    typedef enum logic [1:0] {
        DMSP_SRC_GEN  = 2'h0,
        DMSP_SRC_EXT  = 2'h1,
        DMSP_SRC_TMR0 = 2'h2,
        DMSP_SRC_RSVD = 2'h3
    } dmsp_src_t;

    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic       rsvd;
        logic       tx_svc;
        logic       rx_svc;
        logic       mp_bit;
        logic       rx_en;
        logic       tx_en;
        logic [2:0] baud_sel;
        dmsp_src_t  clk_src;
        logic       two_stop;
        logic       par_odd;
        logic       par_en;
        dmsp_mode_t mode;
    } dmsp_cfg_t;

    // Sticky event layout, rx_done at bit 0
    typedef struct packed {
        logic tx_done;
        logic overrun;
        logic parity_err;
        logic frame_err;
        logic rx_done;
    } dmsp_evt_t;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP,
                  TX_SYNC} dmsp_tx_state_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP,
                  RX_SYNC} dmsp_rx_state_t;

endpackage

/* dmsp_serial_comm_port.sv */
// Dual mode serial port: async start-stop and clock-synchronous modes
`timescale 1ns/10ps
`default_nettype none
`include "dmsp_defines.svh"

module dmsp_serial_comm_port
    import dmsp_pkg::*;
#(
    parameter int CLK_HZ = `DMSP_CLK_HZ
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Serial line
    output logic             txd,
    input  wire logic        rxd,
    // Shift clock pin
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe_n,
    // Reload timer 0 output
    input  wire logic        tmr0_out,
    // Requests
    output logic             irq,
    output logic             rx_svc_req,
    output logic             tx_svc_req
);

    ////////////////////////////////////////////////////////////////////
    // Rate tables
    localparam int AD = `DMSP_OVERSAMPLE;
    localparam logic [11:0] ADIV [0:4] = '{
        12'(CLK_HZ / (`DMSP_ARATE0 * AD)), 12'(CLK_HZ / (`DMSP_ARATE1 * AD)),
        12'(CLK_HZ / (`DMSP_ARATE2 * AD)), 12'(CLK_HZ / (`DMSP_ARATE3 * AD)),
        12'(CLK_HZ / (`DMSP_ARATE4 * AD))};
    localparam logic [11:0] SDIV [0:4] = '{
        12'(CLK_HZ / (`DMSP_SRATE0 * 2)), 12'(CLK_HZ / (`DMSP_SRATE1 * 2)),
        12'(CLK_HZ / (`DMSP_SRATE2 * 2)), 12'(CLK_HZ / (`DMSP_SRATE3 * 2)),
        12'(CLK_HZ / (`DMSP_SRATE4 * 2))};

    // Refuse clocks the divider cannot serve
    if (CLK_HZ / (`DMSP_SRATE0 * 2) < 1 ||
        CLK_HZ / (`DMSP_ARATE4 * AD) > 4095) begin : g_bad_clk
        $error("CLK_HZ outside the divider range");
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    dmsp_cfg_t      cfg_r;
    dmsp_evt_t      st_r, st_set, mask_r;
    logic [15:0]    rdata_nxt;
    logic [11:0]    div_cnt_r, div_sel;
    logic [2:0]     bsel;
    logic           sclk_s1_r, sclk_s2_r, sclk_d_r;
    logic           rxd_s1_r, rxd_s2_r, rxd_d_r;
    logic           tmr_d_r;
    logic           gen_tick, ext_rise, ext_fall, tmr_rise, os_tick;
    logic           is_sync, int_clk, srise, sfall, sclk_gen_r;
    logic [3:0]     ndata;
    logic           has_extra, par_chk;
    // Transmit side
    dmsp_tx_state_t tx_st_r;
    logic [7:0]     tx_buf_r, tx_sh_r;
    logic           tx_full_r, tx_load, tx_extra_r, txd_r, tx_cmp;
    logic [3:0]     tx_bits_r, tx_tick_r;
    logic           tx_bit_end;
    // Receive side
    dmsp_rx_state_t rx_st_r;
    logic [7:0]     rx_sh_r, rx_data;
    logic [8:0]     rx_buf_r;
    logic           rx_full_r, rx_extra_r, rx_cmp, rx_fe, rx_pe;
    logic [3:0]     rx_bits_r, rx_tick_r;
    logic           rx_mid, rx_end;
    // Decodes
    logic           wr_ctrl, wr_tx, wr_st, wr_mask, rd_rx;

    ////////////////////////////////////////////////////////////////////
    // Address decode
    assign wr_ctrl = reg_wr && reg_addr == `DMSP_OFS_CTRL;
    assign wr_tx   = reg_wr && reg_addr == `DMSP_OFS_TXDATA;
    assign wr_st   = reg_wr && reg_addr == `DMSP_OFS_STATUS;
    assign wr_mask = reg_wr && reg_addr == `DMSP_OFS_MASK;
    assign rd_rx   = reg_rd && reg_addr == `DMSP_OFS_RXDATA;

    // Read data select, unmapped reads zero
    assign rdata_nxt =
        reg_addr == `DMSP_OFS_CTRL   ? 16'(cfg_r) :
        reg_addr == `DMSP_OFS_TXDATA ? {8'h00, tx_buf_r} :
        reg_addr == `DMSP_OFS_RXDATA ? {7'h00, rx_buf_r} :
        reg_addr == `DMSP_OFS_STATUS ? {5'h00, tx_st_r != TX_IDLE,
                                        rx_full_r, tx_full_r, 3'h0,
                                        5'(st_r)} :
        reg_addr == `DMSP_OFS_MASK   ? {11'h000, 5'(mask_r)} : 16'h0000;

    // Control, mask and read data registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_r     <= dmsp_cfg_t'(`DMSP_CTRL_RST);
            mask_r    <= dmsp_evt_t'(`DMSP_MASK_RST);
            reg_rdata <= 16'h0000;
        end else begin
            if (wr_ctrl) cfg_r <= dmsp_cfg_t'(reg_wdata);
            if (wr_mask) mask_r <= dmsp_evt_t'(reg_wdata[4:0]);
            reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Events and requests
    assign st_set = '{tx_done: tx_cmp, overrun: rx_cmp && rx_full_r && !rd_rx,
                      parity_err: rx_pe, frame_err: rx_fe,
                      rx_done: rx_cmp && !(rx_full_r && !rd_rx)};

    // Sticky status, set beats write-one clear
    always_ff @(posedge ref_clk) begin
        if (rst) st_r <= dmsp_evt_t'(5'h00);
        else st_r <= st_set | (st_r & ~(wr_st ? reg_wdata[4:0] : 5'h00));
    end

    // Receive request from completion or any error
    logic rx_req, tx_req;
    assign rx_req = |(4'(st_r) & 4'(mask_r));
    assign tx_req = st_r.tx_done && mask_r.tx_done;
    // Route each request to interrupt or transfer service
    assign irq        = (rx_req && !cfg_r.rx_svc) || (tx_req && !cfg_r.tx_svc);
    assign rx_svc_req = rx_req && cfg_r.rx_svc;
    assign tx_svc_req = tx_req && cfg_r.tx_svc;

    ////////////////////////////////////////////////////////////////////
    // Frame shape
    assign is_sync   = cfg_r.mode == DMSP_SYNC;
    // Parity only in async normal mode
    assign par_chk   = cfg_r.mode == DMSP_ASYNC_NORMAL && cfg_r.par_en;
    // Seven bits with parity, else eight
    assign ndata     = par_chk ? 4'h7 : 4'h8;
    assign has_extra = par_chk || cfg_r.mode == DMSP_ASYNC_MP;

    ////////////////////////////////////////////////////////////////////
    // Rate generator and clock sources
    assign bsel    = cfg_r.baud_sel > 3'h4 ? 3'h4 : cfg_r.baud_sel;
    assign div_sel = is_sync ? SDIV[bsel] : ADIV[bsel];
    assign gen_tick = div_cnt_r == 12'h000;

    // Divider reloads each tick
    always_ff @(posedge ref_clk) begin
        if (rst || gen_tick) div_cnt_r <= rst ? 12'h000 : div_sel - 12'h001;
        else div_cnt_r <= div_cnt_r - 12'h001;
    end

    // Pin synchronisers and edge history
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {sclk_s1_r, sclk_s2_r, sclk_d_r} <= 3'h7;
            {rxd_s1_r, rxd_s2_r, rxd_d_r}    <= 3'h7;
            tmr_d_r <= 1'b0;
        end else begin
            {sclk_s1_r, sclk_s2_r, sclk_d_r} <= {sclk_in, sclk_s1_r, sclk_s2_r};
            {rxd_s1_r, rxd_s2_r, rxd_d_r}    <= {rxd, rxd_s1_r, rxd_s2_r};
            tmr_d_r <= tmr0_out;
        end
    end

    assign ext_rise = sclk_s2_r && !sclk_d_r;
    assign ext_fall = !sclk_s2_r && sclk_d_r;
    assign tmr_rise = tmr0_out && !tmr_d_r;
    // Tick from generator, pin, or timer 0
    assign os_tick = cfg_r.clk_src == DMSP_SRC_EXT  ? ext_rise :
                     cfg_r.clk_src == DMSP_SRC_TMR0 ? tmr_rise : gen_tick;

    // Sync shift clock: driven here unless the pin supplies it
    assign int_clk   = cfg_r.clk_src != DMSP_SRC_EXT;
    assign srise     = int_clk ? os_tick && !sclk_gen_r && tx_st_r == TX_SYNC
                               : ext_rise;
    assign sfall     = int_clk ? os_tick && sclk_gen_r && tx_st_r == TX_SYNC
                               : ext_fall;
    assign sclk_out  = sclk_gen_r;
    assign sclk_oe_n = !(is_sync && int_clk);

    // Generated shift clock, idle high
    always_ff @(posedge ref_clk) begin
        if (rst || tx_st_r != TX_SYNC) sclk_gen_r <= 1'b1;
        else if (os_tick && int_clk) sclk_gen_r <= !sclk_gen_r;
    end

    ////////////////////////////////////////////////////////////////////
    // Transmitter
    // Load the shifter from the buffer when idle
    assign tx_load    = tx_st_r == TX_IDLE && tx_full_r && cfg_r.tx_en;
    assign tx_bit_end = os_tick && tx_tick_r == `DMSP_LAST_TICK;
    assign tx_cmp     = (tx_st_r == TX_SYNC && srise && tx_bits_r == 4'h7) ||
                        (tx_st_r == TX_STOP && tx_bit_end &&
                         !(cfg_r.two_stop && tx_bits_r == 4'h0));
    // Line driven only from a flip-flop
    assign txd = txd_r;

    // Buffer: a write while loading queues the new byte
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_buf_r  <= 8'h00;
            tx_full_r <= 1'b0;
        end else begin
            if (wr_tx) tx_buf_r <= reg_wdata[7:0];
            tx_full_r <= wr_tx || (tx_full_r && !tx_load);
        end
    end

    // Async bit timer
    always_ff @(posedge ref_clk) begin
        if (rst || tx_load) tx_tick_r <= 4'h0;
        else if (os_tick) tx_tick_r <= tx_tick_r + 4'h1;
    end

    // Transmit sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_st_r    <= TX_IDLE;
            tx_sh_r    <= 8'h00;
            tx_bits_r  <= 4'h0;
            tx_extra_r <= 1'b0;
            txd_r      <= 1'b1;
        end else begin
            case (tx_st_r)
                TX_IDLE: if (tx_load) begin
                    tx_sh_r    <= tx_buf_r;
                    tx_bits_r  <= 4'h0;
                    // Extra bit: parity or master's mark
                    tx_extra_r <= par_chk ? ^tx_buf_r[6:0] ^ cfg_r.par_odd
                                          : cfg_r.mp_bit;
                    // Sync starts on data, async on start bit
                    tx_st_r    <= is_sync ? TX_SYNC : TX_START;
                    txd_r      <= is_sync ? tx_buf_r[0] : 1'b0;
                end
                TX_START: if (tx_bit_end) begin
                    tx_st_r <= TX_DATA;
                    txd_r   <= tx_sh_r[0];
                end
                TX_DATA: if (tx_bit_end) begin
                    tx_sh_r   <= tx_sh_r >> 1;
                    tx_bits_r <= tx_bits_r + 4'h1;
                    txd_r     <= tx_sh_r[1];
                    if (tx_bits_r == ndata - 4'h1) begin
                        tx_bits_r <= 4'h0;
                        tx_st_r   <= has_extra ? TX_EXTRA : TX_STOP;
                        txd_r     <= has_extra ? tx_extra_r : 1'b1;
                    end
                end
                TX_EXTRA: if (tx_bit_end) begin
                    tx_st_r <= TX_STOP;
                    txd_r   <= 1'b1;
                end
                TX_STOP: if (tx_bit_end) begin
                    tx_bits_r <= 4'h1;
                    if (tx_cmp) tx_st_r <= TX_IDLE;
                end
                // Data only, shifted on falling edges
                TX_SYNC: begin
                    if (srise) tx_bits_r <= tx_bits_r + 4'h1;
                    if (sfall && tx_bits_r != 4'h0) begin
                        tx_sh_r <= tx_sh_r >> 1;
                        txd_r   <= tx_sh_r[1];
                    end
                    if (tx_cmp) tx_st_r <= TX_IDLE;
                end
                default: tx_st_r <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receiver
    assign rx_mid  = os_tick && rx_tick_r == `DMSP_MID_TICK;
    // Stop bit judged at its middle, like the data bits
    assign rx_end  = rx_mid && rx_st_r == RX_STOP;
    assign rx_data = ndata == 4'h7 ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;
    assign rx_cmp  = (rx_st_r == RX_STOP && rx_end) ||
                     (rx_st_r == RX_SYNC && srise && rx_bits_r == 4'h7);
    // Framing checked on the stop bit, async only
    assign rx_fe   = rx_st_r == RX_STOP && rx_end && !rxd_s2_r;
    assign rx_pe   = rx_st_r == RX_STOP && rx_end && par_chk &&
                     (rx_extra_r != (^rx_data[6:0] ^ cfg_r.par_odd));

    // Receive bit timer, held at zero while idle so it starts at the falling edge of a start bit
    always_ff @(posedge ref_clk) begin
        if (rst || rx_st_r == RX_IDLE) rx_tick_r <= 4'h0;
        else if (os_tick) rx_tick_r <= rx_tick_r + 4'h1;
    end

    // Receive sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_st_r    <= RX_IDLE;
            rx_sh_r    <= 8'h00;
            rx_bits_r  <= 4'h0;
            rx_extra_r <= 1'b0;
        end else if (!cfg_r.rx_en) begin
            rx_st_r <= RX_IDLE;
        end else begin
            case (rx_st_r)
                RX_IDLE: begin
                    rx_bits_r <= 4'h0;
                    if (is_sync) rx_st_r <= RX_SYNC;
                    else if (!rxd_s2_r && rxd_d_r) rx_st_r <= RX_START;
                end
                // Start bit must still be low at mid-bit
                RX_START: if (rx_mid) begin
                    rx_st_r <= rxd_s2_r ? RX_IDLE : RX_DATA;
                end
                // Sampling at the middle of each 16-tick window
                RX_DATA: if (rx_mid && rx_tick_r == `DMSP_MID_TICK) begin
                    rx_sh_r   <= {rxd_s2_r, rx_sh_r[7:1]};
                    rx_bits_r <= rx_bits_r + 4'h1;
                    if (rx_bits_r == ndata - 4'h1)
                        rx_st_r <= has_extra ? RX_EXTRA : RX_STOP;
                end
                RX_EXTRA: if (rx_mid) begin
                    rx_extra_r <= rxd_s2_r;
                    rx_st_r    <= RX_STOP;
                end
                RX_STOP: if (rx_end) rx_st_r <= RX_IDLE;
                // Sync: eight data bits on rising edges
                RX_SYNC: begin
                    if (!is_sync) rx_st_r <= RX_IDLE;
                    if (srise) begin
                        rx_sh_r   <= {rxd_s2_r, rx_sh_r[7:1]};
                        rx_bits_r <= rx_bits_r + 4'h1;
                        if (rx_bits_r == 4'h7) rx_bits_r <= 4'h0;
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // Receive buffer; a full one keeps its byte on overrun
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_buf_r  <= 9'h000;
            rx_full_r <= 1'b0;
        end else begin
            if (rx_cmp && !(rx_full_r && !rd_rx)) begin
                rx_buf_r  <= {rx_extra_r && !is_sync && !par_chk,
                              is_sync ? {rxd_s2_r, rx_sh_r[7:1]} : rx_data};
                rx_full_r <= 1'b1;
            end else if (rd_rx) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    // Master only: every received byte is delivered unfiltered

endmodule
`default_nettype wire

/* dmsp_chk.sv */
// Port-level assertion checker for the dual mode serial port
`timescale 1ns/10ps
`default_nettype none
module dmsp_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Line and requests
    input wire logic        txd,
    input wire logic        sclk_out,
    input wire logic        sclk_oe_n,
    input wire logic        irq,
    input wire logic        tx_svc_req
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Read data only in the cycle after a read strobe
    chk_rdata_quiet: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    chk_unmapped_zero: assert property (
        $past(reg_rd) && $past(reg_addr) > 4'h4 |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_status_spare: assert property (
        $past(reg_rd) && $past(reg_addr) == 4'h3
        |-> reg_rdata[15:11] == 5'h00 && reg_rdata[7:5] == 3'h0)
        else $error("status spare bits set");
    // Line and clock pin idle states, serial level hold
    chk_reset_idle: assert property (
        $fell(rst) |-> txd && sclk_out && !irq && !tx_svc_req)
        else $error("outputs not idle after reset");
    chk_nrz_hold: assert property (
        $changed(txd) |=> $stable(txd)[*8])
        else $error("serial level not held");
    chk_sclk_idle: assert property (
        sclk_oe_n |-> sclk_out)
        else $error("shift clock moves while released");
    // Masking and clearing silence the request
    chk_mask_off: assert property (
        reg_wr && reg_addr == 4'h4 && reg_wdata[4:0] == 5'h00 |=> !irq)
        else $error("irq with all events masked");
    chk_w1c_clear: assert property (
        reg_wr && reg_addr == 4'h3 && reg_wdata[4:0] == 5'h1F
        |=> !irq && !tx_svc_req)
        else $error("request after clearing all events");
endmodule

bind dmsp_serial_comm_port dmsp_chk i_chk (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .txd(txd), .sclk_out(sclk_out),
    .sclk_oe_n(sclk_oe_n), .irq(irq), .tx_svc_req(tx_svc_req)
);
`default_nettype wire

/* dmsp_peer.sv */
// Far-side serial device: captures frames and sends frames
`timescale 1ns/10ps
`default_nettype none
module dmsp_peer #(
    parameter int BIT_NS = 3200
) (
    // Serial line
    input  wire logic txd,
    output logic      rxd
);
    int          nb    = 9;
    int          n_frm = 0;
    int          bit_ns = BIT_NS;
    logic [11:0] frm   = 12'hFFF;
    initial rxd = 1'b1;

    always begin
        @(negedge txd);
        frm = 12'hFFF;
        #(bit_ns / 2);
        for (int i = 0; i < nb; i++) begin
            #(bit_ns);
            frm[i] = txd;
        end
        n_frm++;
    end

    task automatic send(input logic [23:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            rxd = b[i];
            #(bit_ns);
        end
        rxd = 1'b1;
    endtask
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the dual mode serial port
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        ref_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic [3:0]  reg_addr  = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        sclk_in   = 1'b0;
    logic [2:0]  tdiv      = 3'h0;
    logic [15:0] reg_rdata, d;
    logic [11:0] e;
    logic [23:0] f;
    logic        txd, rxd, sclk_out, sclk_oe_n, irq, rx_svc_req, tx_svc_req;
    int          error_cnt  = 0;
    int          n_compared = 0;

    // Machine clock and free-running rate clock on the pin
    always #12.5 ref_clk = ~ref_clk;
    initial #7 forever #100 sclk_in = ~sclk_in;
    // Timer 0 stand-in: a rising edge every eight clocks
    always @(posedge ref_clk) tdiv <= tdiv + 3'h1;

    dmsp_serial_comm_port i_dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .txd(txd), .rxd(rxd), .sclk_in(sclk_in),
        .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .tmr0_out(tdiv[2]),
        .irq(irq), .rx_svc_req(rx_svc_req), .tx_svc_req(tx_svc_req)
    );
    dmsp_peer i_peer (.txd(txd), .rxd(rxd));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] b16(input logic x);
        return {15'h0000, x};
    endfunction
    function automatic logic [11:0] fr(input logic [7:0] x);
        return {3'b111, x, 1'b0};
    endfunction
    task automatic chk(input string nm, input logic [15:0] x,
                       input logic [15:0] g);
        n_compared++;
        if (g !== x) begin
            $display("Error %s expected %h seen %h", nm, x, g);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic wait_st(input int b);
        for (int i = 0; i < 10000; i++) begin
            rd(4'h3, d);
            if (d[b] === 1'b1) return;
        end
        chk("status wait", 16'h0001, 16'h0000);
    endtask
    task automatic test_done;
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        logic [3:0] a [4] = '{4'h0, 4'h3, 4'h4, 4'hF};
        wr(4'hF, 16'hFFFF);
        foreach (a[i]) begin
            rd(a[i], d);
            chk("reset read", 16'h0000, d);
        end
        chk("idle txd", 16'h0001, b16(txd));
    endtask
    task automatic t_tx(input logic [15:0] c, input logic [7:0] v,
                        input int n, input logic [11:0] x);
        int n0;
        wr(4'h0, c);
        wr(4'h3, 16'h001F);
        n0 = i_peer.n_frm;
        i_peer.nb = n;
        wr(4'h1, {8'h00, v});
        wait_st(4);
        chk("tx frame", {4'h0, x}, {4'h0, i_peer.frm});
        chk("tx count", 16'h0001, 16'(i_peer.n_frm - n0));
    endtask
    task automatic t_irq;
        wr(4'h4, 16'h0000);
        #1;
        chk("irq masked", 16'h0000, b16(irq));
        wr(4'h4, 16'h0010);
        #1;
        chk("irq tx", 16'h0001, b16(irq));
        wr(4'h0, 16'h4C20);
        #1;
        chk("irq routed", 16'h0000, b16(irq));
        chk("tx svc", 16'h0001, b16(tx_svc_req));
        wr(4'h3, 16'h0010);
        #1;
        chk("svc clear", 16'h0000, b16(tx_svc_req));
    endtask
    task automatic t_dbl;
        int n0;
        wr(4'h0, 16'h0C30);
        wr(4'h3, 16'h001F);
        i_peer.nb = 10;
        n0 = i_peer.n_frm;
        wr(4'h1, 16'h0011);
        wr(4'h1, 16'h0022);
        rd(4'h3, d);
        chk("tx full", 16'h0100, d & 16'h0100);
        wait_st(4);
        wr(4'h3, 16'h0010);
        wait_st(4);
        chk("second frame", 16'h0F22, {4'h0, i_peer.frm});
        chk("frames", 16'h0002, 16'(i_peer.n_frm - n0));
    endtask
    task automatic t_rx(input logic [15:0] c, input logic [23:0] b,
                        input logic [4:0] m, input logic [4:0] x,
                        input logic [7:0] v, input logic [7:0] dm);
        wr(4'h0, c);
        wr(4'h3, 16'h001F);
        i_peer.send(b, 24);
        rd(4'h3, d);
        chk("rx status", {11'h0, x}, {11'h0, d[4:0] & m});
        chk("rx irq", b16(!c[13]), b16(irq));
        chk("rx svc", b16(c[13]), b16(rx_svc_req));
        rd(4'h2, d);
        chk("rx data", {8'h00, v}, {8'h00, d[7:0] & dm});
    endtask
    task automatic t_sync;
        logic [7:0] s;
        wr(4'h0, 16'h0C02);
        wr(4'h3, 16'h001F);
        #1;
        chk("sclk drive", 16'h0000, b16(sclk_oe_n));
        wr(4'h1, 16'h00A5);
        for (int i = 0; i < 8; i++) begin
            @(posedge sclk_out);
            s[i] = txd;
        end
        wait_st(4);
        chk("sync data", 16'h00A5, {8'h00, s});
        rd(4'h2, d);
        chk("sync rx", 16'h00FF, d);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; multiprocessor setups keep parity off
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_tx(16'h0C20, 8'hA5, 9, 12'hFA5);
        i_peer.bit_ns = 32000;
        t_tx(16'h0C00, 8'hA5, 9, 12'hFA5);
        i_peer.bit_ns = 3200;
        t_tx(16'h0C40, 8'hA5, 9, 12'hFA5);
        for (int o = 0; o < 2; o++) begin
            e = {4'hF, 1'(o) ^ (^7'h35), 7'h35};
            t_tx(16'h0C34 | 16'(o << 3), 8'hB5, 10, e);
        end
        for (int m = 0; m < 2; m++) begin
            e = {3'h7, 1'(m), 8'hA5};
            t_tx(16'h0C21 | 16'(m << 12), 8'hA5, 10, e);
        end
        t_irq();
        t_dbl();
        wr(4'h4, 16'h001F);
        f = {12'hFFF, fr(8'h3C)};
        t_rx(16'h0C20, f, 5'h0F, 5'h01, 8'h3C, 8'hFF);
        f = {12'hFFF, fr({1'b0, 7'h35})};
        t_rx(16'h0C24, f, 5'h0F, 5'h01, 8'h35, 8'h7F);
        f = {12'hFFF, fr({1'b1, 7'h35})};
        t_rx(16'h0C24, f, 5'h04, 5'h04, 8'h00, 8'h00);
        f = {12'hFFF, 3'b110, 8'h3C, 1'b0};
        t_rx(16'h0C20, f, 5'h02, 5'h02, 8'h00, 8'h00);
        f = {fr(8'h5A), fr(8'h3C)};
        t_rx(16'h2C20, f, 5'h09, 5'h09, 8'h3C, 8'hFF);
        t_sync();
        test_done();
    end

    // Hang guard well beyond the expected run
    initial begin
        #2000000;
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
